// >>> bench/sps_platform.sv
// platform model: wake sources pulsing their event lines
module sps_platform (
	input  wire        mclk,
	input  wire        fire,
	input  wire [1:0]  src,
	output logic [3:0] wake_event
);
	timeunit 1ns;
	timeprecision 100ps;
	initial wake_event = 4'h0;
	// one-cycle pulse, so only a latched event can cause a wake
	always @(posedge mclk) wake_event <= #2 fire ? 4'h1 << src : 4'h0;
endmodule

// >>> bench/sps_seq_monitor.sv
// assertions on the sleep-state sequencer ports
module sps_seq_monitor #(parameter WAKE_N = 4, PASS_CYC = 4) (
	input wire mclk, arst_n, ce, sleep_enable_bit, sleep_sel, proc_idle,
	input wire button_override, power_fail, reboot_on_return, battery_low_n,
	input wire [WAKE_N-1:0] wake_event, wake_enable, wake_keep,
	input wire [2:0] state_q,
	input wire full_boot_q, min_power_loaded_q, wake_pending_q
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	wire go = ce && !power_fail;
	wire hit = |(wake_event & wake_enable);
	////////////////
	property p_sleep; go && !button_override && state_q == 3'h0 && sleep_enable_bit && sleep_sel
		|=> state_q == 3'h2 ##[3:5] state_q == 3'h3; endproperty
	a_sleep: assert property (p_sleep) else $error("soft-off pass wrong");
	property p_fail; ce && power_fail |=> state_q == 3'h4; endproperty
	a_fail: assert property (p_fail) else $error("no mech-off");
	property p_mech; state_q == 3'h4 && power_fail |=> state_q == 3'h4 && !full_boot_q; endproperty
	a_mech: assert property (p_mech) else $error("left mech-off");
	property p_low; state_q inside {3'h2, 3'h3} && !battery_low_n |=> state_q != 3'h0; endproperty
	a_low: assert property (p_low) else $error("boot in battery low");
	property p_ovr; go && button_override && state_q inside {3'h0, 3'h1, 3'h2}
		|=> state_q inside {3'h2, 3'h3}; endproperty
	a_ovr: assert property (p_ovr) else $error("override ignored");
	property p_wake; go && battery_low_n && state_q == 3'h3 && hit ##1 go && battery_low_n
		|=> state_q == 3'h0; endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	property p_ret; go && state_q == 3'h4 |=> $past(reboot_on_return) && $past(battery_low_n) ?
		state_q == 3'h0 : state_q inside {3'h2, 3'h3}; endproperty
	a_ret: assert property (p_ret) else $error("bad power return");
	property p_boot; state_q == 3'h0 && $past(state_q) inside {3'h2, 3'h3, 3'h4}
		|-> full_boot_q && min_power_loaded_q; endproperty
	a_boot: assert property (p_boot) else $error("boot not flagged");
	property p_minp; state_q == 3'h4 && $past(state_q) == 3'h4 |-> !min_power_loaded_q; endproperty
	a_minp: assert property (p_minp) else $error("settings kept");
	property p_pend; go && state_q == 3'h3 && hit |-> ##2 wake_pending_q; endproperty
	a_pend: assert property (p_pend) else $error("no pending");
	property p_slpx; go && !button_override && state_q == 3'h1 && proc_idle
		|=> state_q == 3'h1; endproperty
	a_slpx: assert property (p_slpx) else $error("left idle");
	property p_hold; !ce |=> $stable(state_q) && $stable(min_power_loaded_q); endproperty
	a_hold: assert property (p_hold) else $error("moved while frozen");
	c_boot: cover property (full_boot_q);
	c_off: cover property (state_q == 3'h3);
	c_mech: cover property (state_q == 3'h4 && !power_fail);
	c_idle: cover property (state_q == 3'h1);
endmodule
bind sps_sequencer sps_seq_monitor #(.WAKE_N(WAKE_N), .PASS_CYC(PASS_CYC)) u_mon (
	.mclk(mclk), .arst_n(arst_n), .ce(ce), .sleep_enable_bit(sleep_enable_bit),
	.sleep_sel(sleep_sel), .proc_idle(proc_idle), .button_override(button_override),
	.power_fail(power_fail), .reboot_on_return(reboot_on_return),
	.battery_low_n(battery_low_n), .wake_event(wake_event), .wake_enable(wake_enable),
	.wake_keep(wake_keep), .state_q(state_q), .full_boot_q(full_boot_q),
	.min_power_loaded_q(min_power_loaded_q), .wake_pending_q(wake_pending_q));

// >>> bench/tb.sv
// self-checking bench for the sleep-state sequencer
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 0, arst_n = 0, slp = 0, sel = 0, ovr = 0, pf = 0, reb = 1, bl_n = 1, fire = 0;
	logic en = 1, idle = 0;
	logic [1:0] src = 0;
	logic [3:0] wen = 4'h0, keep = 4'h0, wev;
	logic [2:0] st;
	logic fb, mpl, wp;
	int err_count = 0, cmp_count = 0;
	initial forever #12.5 mclk = ~mclk;
	sps_platform PLAT (.mclk(mclk), .fire(fire), .src(src), .wake_event(wev));
	sps_sequencer DUT (.mclk(mclk), .arst_n(arst_n), .ce(en), .sleep_enable_bit(slp),
		.sleep_sel(sel), .proc_idle(idle), .button_override(ovr), .wake_event(wev),
		.wake_enable(wen), .wake_keep(keep), .power_fail(pf), .reboot_on_return(reb),
		.battery_low_n(bl_n), .state_q(st), .full_boot_q(fb),
		.min_power_loaded_q(mpl), .wake_pending_q(wp));
	////////////////
	task step(int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	task chk(string nm, logic [2:0] exp, logic [2:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task chk_flag(string nm, logic exp, logic got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %b seen %b", nm, exp, got);
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task wait_st(logic [2:0] v);
		for (int i = 0; i < 40 && st !== v; i++) step(1);
		chk("state", v, st);
		if (st !== v) test_done();
	endtask
	task wake(int s);
		src = s;
		fire = 1;
		step(1);
		fire = 0;
	endtask
	task sleep_to(logic s);
		sel = s;
		slp = 1;
		step(1);
		slp = 0;
	endtask
	////////////////
	task t_off;
		sleep_to(1'b1);
		chk("state", 3'h2, st);
		wait_st(3'h3);
		bl_n = 0;
		wen = 4'h2;
		wake(1);
		step(6);
		chk("state", 3'h3, st);
		chk_flag("wake_pending", 1'b1, wp);
		bl_n = 1;
		wait_st(3'h0);
		chk_flag("full_boot", 1'b1, fb);
		chk_flag("min_power", 1'b1, mpl);
		step(1);
		chk_flag("full_boot", 1'b0, fb);
	endtask
	task t_idle;
		idle = 1;
		step(1);
		chk("state", 3'h1, st);
		sleep_to(1'b1);
		chk("state", 3'h1, st);
		en = 0;
		idle = 0;
		ovr = 1;
		step(3);
		chk("state", 3'h1, st);
		en = 1;
		step(1);
		ovr = 0;
		chk("state", 3'h3, st);
		wen = 4'h1;
		wake(0);
		wait_st(3'h0);
	endtask
	task t_ret;
		wen = 4'h9;
		wake(0);
		step(2);
		chk_flag("wake_pending", 1'b1, wp);
		pf = 1;
		step(1);
		wake(3);
		chk("state", 3'h4, st);
		chk_flag("min_power", 1'b0, mpl);
		pf = 0;
		step(4);
		chk("state", 3'h3, st);
		chk_flag("wake_pending", 1'b0, wp);
		chk_flag("min_power", 1'b0, mpl);
		wake(0);
		wait_st(3'h0);
		chk_flag("min_power", 1'b1, mpl);
	endtask
	task t_ovr;
		ovr = 1;
		step(1);
		ovr = 0;
		wait_st(3'h3);
		wen = 4'h1;
		wake(2);
		step(4);
		chk("state", 3'h3, st);
		wake(0);
		wait_st(3'h0);
	endtask
	task t_fail;
		sleep_to(1'b0);
		chk("state", 3'h2, st);
		keep = 4'h8;
		wen = 4'h8;
		reb = 0;
		wake(3);
		step(1);
		pf = 1;
		step(3);
		chk("state", 3'h4, st);
		chk_flag("min_power", 1'b0, mpl);
		pf = 0;
		step(1);
		chk("state", 3'h2, st);
		wait_st(3'h0);
	endtask
	initial begin
		step(6);
		arst_n = 1;
		step(2);
		chk("state", 3'h0, st);
		t_off();
		t_ovr();
		t_idle();
		t_fail();
		t_ret();
		test_done();
	end
endmodule

// >>> verilog/sps_defs.vh
// constants for the system sleep-state sequencer
`ifndef SPS_DEFS_VH
`define SPS_DEFS_VH
// state encodings (also driven out on the state port)
`define SPS_ST_FULL_ON   3'h0
`define SPS_ST_IDLE      3'h1
`define SPS_ST_SUSP_DISK 3'h2
`define SPS_ST_SOFT_OFF  3'h3
`define SPS_ST_MECH_OFF  3'h4
`define SPS_ST_WIDTH     3
// software sleep target selection
`define SPS_SEL_DISK     1'h0
`define SPS_SEL_OFF      1'h1
// time spent passing through suspend-to-disk on the way to soft-off
`define SPS_PASS_NS      100
`define SPS_PASS_CYC     ((`SPS_PASS_NS + 24) / 25)
// number of wake sources
`define SPS_WAKE_N       4
`endif

// >>> verilog/sps_sequencer.v
// system sleep-state sequencer for the always-on domain
//
// What this block does
// (RULE1) soft-off entry may pass through suspend-to-disk
// (RULE2) enabled wake in disk/off returns full-on
// (RULE3) battery low holds off wake to full-on
// (RULE4) button override forces soft-off until wake
// (RULE5) power return: reboot or stay soft-off
// (RULE6) from suspend-to-disk: full-on or back there
// (RULE7) chosen wake events survive power failure
// (RULE8) low-power settings loaded on first boot only
// (RULE9) leaving soft-off requests a full boot
// (RULE10) mechanical-off recognises no wake events
// (RULE11) sleep bit enters selected state; failure forces mech-off; the sleep bit is taken in full-on only, idle ignores it
//
// state_q codes: 0 full-on, 1 idle, 2 suspend-to-disk, 3 soft-off,
// 4 mechanical-off; reset stands for the loss of all power
// full_boot_q pulses for one cycle on every boot into full-on
// wake_pending_q follows the wake latches one cycle late
// inputs apart from the asynchronous arst_n are taken as synchronous to mclk; none is resynchronised
// a boot from any sleep state or from mech-off waits for battery_low_n
`include "sps_defs.vh"
module sps_sequencer #(
	parameter WAKE_N   = `SPS_WAKE_N,
	parameter PASS_CYC = `SPS_PASS_CYC
) (
	input  wire                    mclk,
	input  wire                    arst_n,
	input  wire                    ce,
	input  wire                    sleep_enable_bit,
	input  wire                    sleep_sel,
	input  wire                    proc_idle,
	input  wire                    button_override,
	input  wire [WAKE_N-1:0]       wake_event,
	input  wire [WAKE_N-1:0]       wake_enable,
	input  wire [WAKE_N-1:0]       wake_keep,
	input  wire                    power_fail,
	input  wire                    reboot_on_return,
	input  wire                    battery_low_n,
	output reg  [`SPS_ST_WIDTH-1:0] state_q,
	output reg                     full_boot_q,
	output reg                     min_power_loaded_q,
	output reg                     wake_pending_q
);
	////////////////////////////////////////////////////////////////////////
	localparam ST_FULL_ON   = `SPS_ST_FULL_ON;
	localparam ST_IDLE      = `SPS_ST_IDLE;
	localparam ST_SUSP_DISK = `SPS_ST_SUSP_DISK;
	localparam ST_SOFT_OFF  = `SPS_ST_SOFT_OFF;
	localparam ST_MECH_OFF  = `SPS_ST_MECH_OFF;
	// priority in full-on: power failure, then the button override,
	// then the sleep request, then processor idle
	// a wake that lands in the cycle of a boot from a sleep state stays pending and ends the
	// next sleep at once; set-wins was chosen so that no event is lost
	// the pass-through counter is 16 bits, so PASS_CYC must stay below 65536

	reg  [`SPS_ST_WIDTH-1:0] state_d;
	reg                      was_disk_q;
	reg                      was_disk_d;
	reg                      to_off_q;
	reg                      to_off_d;
	reg  [15:0]              pass_cnt_q;
	reg  [15:0]              pass_cnt_d;
	reg                      boot_d;
	reg                      min_power_d;
	wire                     pf_entry;
	wire                     pass_done;
	wire                     wake_go;
	wire [WAKE_N-1:0]        pend;
	wire                     any_wake;
	wire                     in_sleep;
	wire                     wake_clear;

	assign in_sleep = (state_q == ST_SUSP_DISK) || (state_q == ST_SOFT_OFF);
	assign any_wake = |pend;
	// pending wakes are consumed on the boot that acts on them
	assign wake_clear = boot_d;

	// a boot from a sleep state waits for a latched wake and a good battery
	assign wake_go   = in_sleep && any_wake && battery_low_n; // [RULE2] [RULE3]
	// the pass-through has run its course once PASS_CYC cycles were spent
	assign pass_done = (pass_cnt_q >= PASS_CYC[15:0] - 16'h0001); // [RULE1]
	assign pf_entry  = power_fail && (state_q != ST_MECH_OFF);

	////////////////////////////////////////////////////////////////////////
	// wake latches; mech-off masks new events, kept ones are retained
	genvar gi;
	generate
		for (gi = 0; gi < WAKE_N; gi = gi + 1) begin : g_wake
			sps_wake_latch u_latch (
				.mclk         (mclk),
				.arst_n       (arst_n),
				.ce           (ce),
				.event_in     (wake_event[gi] && (state_q != ST_MECH_OFF)), // [RULE10]
				.enable       (wake_enable[gi]),
				.keep_on_fail (wake_keep[gi]), // [RULE7]
				.power_fail   (power_fail),
				.clear        (wake_clear),
				.pend_q       (pend[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	always @* begin
		state_d    = state_q;
		was_disk_d = was_disk_q;
		to_off_d   = to_off_q;
		pass_cnt_d = pass_cnt_q;
		boot_d     = 1'b0;

		if (power_fail) begin
			state_d = ST_MECH_OFF; // [RULE11]
			to_off_d = 1'b0;
		end else begin
			case (state_q)
			// working state: override, sleep and idle requests are taken here
			ST_FULL_ON: begin
				if (button_override) begin
					state_d = ST_SOFT_OFF; // [RULE4]
				end else if (sleep_enable_bit) begin // [RULE11]
					state_d    = ST_SUSP_DISK; // [RULE1]
					to_off_d   = (sleep_sel == `SPS_SEL_OFF);
					pass_cnt_d = 16'h0000;
				end else if (proc_idle) begin
					state_d = ST_IDLE;
				end
			end

			// processor idle: back to full-on when it has work again
			ST_IDLE: begin
				if (button_override)
					state_d = ST_SOFT_OFF; // [RULE4]
				else if (!proc_idle)
					state_d = ST_FULL_ON;
			end

			// context on disk, or only passing through on the way to soft-off
			ST_SUSP_DISK: begin
				if (button_override) begin
					state_d  = ST_SOFT_OFF; // [RULE4]
					to_off_d = 1'b0;
				end else if (to_off_q) begin
					// visible pass-through on the way to soft-off
					if (pass_done) begin // [RULE1]
						state_d  = ST_SOFT_OFF;
						to_off_d = 1'b0;
					end else begin
						pass_cnt_d = pass_cnt_q + 16'h0001;
					end
				end else if (wake_go) begin // [RULE2] [RULE3]
					state_d = ST_FULL_ON;
					boot_d  = 1'b1;
				end
			end

			ST_SOFT_OFF: begin
				// override keeps us here; only a wake or a power failure leaves
				if (wake_go) begin // [RULE2] [RULE3] [RULE4]
					state_d = ST_FULL_ON;
					boot_d  = 1'b1; // [RULE9]
				end
			end

			ST_MECH_OFF: begin
				// power has returned since power_fail is low here
				if (was_disk_q) begin
					if (reboot_on_return && battery_low_n) begin // [RULE6] [RULE3]
						state_d = ST_FULL_ON;
						boot_d  = 1'b1;
					end else begin
						state_d = ST_SUSP_DISK; // [RULE6]
					end
				end else if (reboot_on_return && battery_low_n) begin // [RULE5]
					state_d = ST_FULL_ON;
					boot_d  = 1'b1;
				end else begin
					state_d = ST_SOFT_OFF; // [RULE5]
				end
			end
			default: state_d = ST_MECH_OFF;
			endcase
		end

		// remember whether mech-off was entered from suspend-to-disk other than a pass-through to soft-off
		if (pf_entry)
			was_disk_d = (state_q == ST_SUSP_DISK) && !to_off_q; // [RULE6]
	end

	////////////////////////////////////////////////////////////////////////
	// settings are lost with power and come back on the first boot after it,
	// so soft-off reached straight from mech-off runs without them
	always @* begin
		min_power_d = min_power_loaded_q;
		if (state_d == ST_MECH_OFF)
			min_power_d = 1'b0; // [RULE8]
		else if (boot_d)
			min_power_d = 1'b1; // [RULE8]
	end

	////////////////////////////////////////////////////////////////////////
	// reset stands for loss of all power, so start in mechanical-off
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_q            <= ST_MECH_OFF;
			was_disk_q         <= 1'b0;
			to_off_q           <= 1'b0;
			pass_cnt_q         <= 16'h0000;
			full_boot_q        <= 1'b0;
			min_power_loaded_q <= 1'b0;
			wake_pending_q     <= 1'b0;
		end else if (ce) begin
			// ce low freezes every register, the wake latches included
			state_q        <= state_d;
			was_disk_q     <= was_disk_d;
			to_off_q       <= to_off_d;
			pass_cnt_q     <= pass_cnt_d;
			full_boot_q    <= boot_d; // [RULE9]
			wake_pending_q <= any_wake;
			min_power_loaded_q <= min_power_d; // [RULE8]
		end
	end
endmodule

// >>> verilog/sps_wake_latch.v
// sticky wake-event latch, one per wake source
`include "sps_defs.vh"
module sps_wake_latch (
	input  wire mclk,
	input  wire arst_n,
	input  wire ce,
	input  wire event_in,
	input  wire enable,
	input  wire keep_on_fail,
	input  wire power_fail,
	input  wire clear,
	output reg  pend_q
);
	// set wins over clear; a kept source survives power failure
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pend_q <= 1'b0;
		end else if (ce) begin
			if (event_in && enable && !power_fail)
				pend_q <= 1'b1;
			else if (clear || (power_fail && !keep_on_fail))
				pend_q <= 1'b0;
		end
	end
endmodule
